/* rtl/flm_flash_ctrl.sv */
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module flm_flash_ctrl #(
	parameter int PWM_PERIOD = flm_pkg::PWM_CYC,
	parameter int SCL_TIMEOUT = flm_pkg::TIMEOUT_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic torch_pin,
	input wire logic trigger_pin,
	input wire logic scl_pin,
	input wire logic [7:0] supply_level,
	output logic [7:0] first_sink_drive,
	output logic [7:0] second_sink_drive,
	output logic shutdown,
	output logic irq
);
	import flm_pkg::*;

	flm_pin_if pins();
	flm_state_e state_reg;
	flm_state_e state_next;
	logic ready_reg;
	logic [31:0] rdata_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [23:0] level_reg;
	logic [15:0] limit_reg;
	logic [15:0] supply_reg;
	logic low_flag_reg;
	logic [IRQ_W-1:0] istat_reg;
	logic [IRQ_W-1:0] imask_reg;
	logic irq_reg;
	logic shut_reg;
	logic [31:0] scl_cnt_reg;
	logic [15:0] step_cnt_reg;
	logic [15:0] dur_cnt_reg;
	logic reduced_reg;
	logic lowered_reg;
	logic [7:0] cur1_reg;
	logic [7:0] cur2_reg;
	logic [7:0] min1_reg;
	logic [7:0] min2_reg;
	logic [7:0] drv1_reg;
	logic [7:0] drv2_reg;

	// Synchronised pins and indicator PWM
	flm_pin_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.torch_raw(torch_pin),
		.trig_raw(trigger_pin),
		.scl_raw(scl_pin),
		.pins(pins.src)
	);
	logic pwm_gate;
	flm_pwm #(.PERIOD(PWM_PERIOD)) u_pwm (
		.hclk(hclk),
		.hresetn(hresetn),
		.duty(ctrl_reg[C_DUTY +: 2]),
		.gate(pwm_gate)
	);

	// Write hit on a register offset in the data phase
	function automatic logic wr_hit(input logic pend, input logic [7:0] wa, input logic [7:0] a);
		wr_hit = pend && (wa == a);
	endfunction

	// One ramp or reduction step of a sink level
	function automatic logic [7:0] step_level(input logic [7:0] cur, input logic [7:0] tgt,
		input logic tick, input logic low, input logic lowered);
		step_level = cur;
		if (cur > tgt) begin
			step_level = tgt;
		end else if (tick && low && (cur != 8'h00)) begin
			step_level = cur - 8'h01;
		end else if (tick && !low && !lowered && (cur < tgt)) begin
			step_level = cur + 8'h01;
		end
	endfunction

	// Control fields
	wire [1:0] mode = ctrl_reg[C_MODE +: 2];
	wire out_on = ctrl_reg[C_OUT_ON];
	wire [1:0] torch_fn = ctrl_reg[C_TORCH +: 2];
	wire strobe_on = ctrl_reg[C_STROBE_ON];
	wire strobe_type = ctrl_reg[C_STROBE_TYPE];
	wire abort_sel = ctrl_reg[C_ABORT];
	wire [7:0] lvl1 = level_reg[7:0];
	wire [7:0] lvl2 = level_reg[15:8];
	wire [7:0] reduced_lvl = level_reg[23:16];
	wire [7:0] pre_lim = supply_reg[7:0];
	wire [7:0] run_lim = supply_reg[15:8];

	// Bus decode
	wire addr_phase = hsel && htrans[1] && hready;
	wire rd_phase = addr_phase && !hwrite;
	wire [7:0] a_addr = haddr[7:0];
	wire fault_rd = rd_phase && (a_addr == A_FAULT);
	wire wr_ctrl = wr_hit(wr_pend_reg, wr_addr_reg, A_CTRL) && !shut_reg;
	wire wr_level = wr_hit(wr_pend_reg, wr_addr_reg, A_LEVEL);
	wire wr_limit = wr_hit(wr_pend_reg, wr_addr_reg, A_LIMIT);
	wire wr_supply = wr_hit(wr_pend_reg, wr_addr_reg, A_SUPPLY);
	wire wr_istat = wr_hit(wr_pend_reg, wr_addr_reg, A_ISTAT);
	wire wr_imask = wr_hit(wr_pend_reg, wr_addr_reg, A_IMASK);

	// Read data selection
	wire [31:0] rd_mux =
		(a_addr == A_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl_reg} :
		(a_addr == A_LEVEL) ? {8'h00, level_reg} :
		(a_addr == A_LIMIT) ? {16'h0000, limit_reg} :
		(a_addr == A_SUPPLY) ? {16'h0000, supply_reg} :
		(a_addr == A_FAULT) ? {31'h00000000, low_flag_reg} :
		(a_addr == A_ISTAT) ? {28'h0000000, istat_reg} :
		(a_addr == A_IMASK) ? {28'h0000000, imask_reg} :
		(a_addr == A_READ) ? {min2_reg, min1_reg, cur2_reg, cur1_reg} :
		(a_addr == A_STATE) ? {28'h0000000, shut_reg, state_reg} :
		32'h00000000;

	// Mode decode
	wire active_mode = out_on && (mode != MODE_EXT);
	wire ext_torch = (mode == MODE_EXT) && (torch_fn == TORCH_EXT) && pins.torch;
	wire flash_en = (mode == MODE_FLASH) && out_on && !shut_reg;
	wire txmask = (torch_fn == TORCH_MASK) && pins.torch;
	wire use_red = txmask || reduced_reg;
	wire [7:0] tgt1 = use_red ? reduced_lvl : lvl1;
	wire [7:0] tgt2 = use_red ? reduced_lvl : lvl2;
	wire run_low = supply_level < run_lim;
	wire pre_low = supply_level < pre_lim;
	wire step_tick = step_cnt_reg == 16'(STEP_CYC - 1);
	wire scl_hit = scl_cnt_reg == 32'(SCL_TIMEOUT - 1);
	wire level_style = strobe_on && strobe_type;
	wire dur_hit = step_tick && (dur_cnt_reg + 16'h0001 >= limit_reg);
	wire [7:0] nxt1 = step_level(cur1_reg, tgt1, step_tick, run_low, lowered_reg);
	wire [7:0] nxt2 = step_level(cur2_reg, tgt2, step_tick, run_low, lowered_reg);

	// Flash sequence decisions
	wire start_req = flash_en && (strobe_on ? pins.trig_rise : 1'b1);
	wire in_check = state_reg == FL_CHECK;
	wire in_run = state_reg == FL_RUN;
	wire abort_now = in_check && pre_low && abort_sel;
	wire run_end = in_run && (!flash_en || dur_hit || (level_style && !pins.trig));
	wire run_low_ev = in_run && step_tick && run_low;
	wire low_ev = (in_check && pre_low) || run_low_ev;
	wire clear_out = (abort_now || run_end) && !strobe_on;

	// Sink drive selection
	wire [7:0] d1 =
		shut_reg ? 8'h00 :
		ext_torch ? (lvl1 & MASK7) :
		!out_on ? 8'h00 :
		(mode == MODE_IND) ? (pwm_gate ? (lvl1 & MASK6) : 8'h00) :
		(mode == MODE_ASSIST) ? (lvl1 & MASK7) :
		in_run ? cur1_reg : 8'h00;
	wire [7:0] d2 =
		shut_reg ? 8'h00 :
		ext_torch ? (lvl2 & MASK7) :
		!out_on ? 8'h00 :
		(mode == MODE_IND) ? (pwm_gate ? (lvl2 & MASK6) : 8'h00) :
		(mode == MODE_ASSIST) ? (lvl2 & MASK7) :
		in_run ? cur2_reg : 8'h00;

	wire [IRQ_W-1:0] ev = {scl_hit, run_end, in_check && !abort_now, low_ev};

	// Bus slave: zero wait state, read data captured in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			ready_reg <= 1'b1;
			rdata_reg <= rd_phase ? rd_mux : 32'h00000000;
			wr_pend_reg <= addr_phase && hwrite;
			wr_addr_reg <= a_addr;
		end
	end

	// Control register, cleared by shutdown
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RST;
		end else if (scl_hit) begin
			ctrl_reg <= CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= hwdata[CTRL_W-1:0];
		end else if (clear_out) begin
			ctrl_reg[C_OUT_ON] <= 1'b0;
		end
	end

	// Level, limit and supply settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_reg <= LEVEL_RST;
			limit_reg <= LIMIT_RST;
			supply_reg <= SUPPLY_RST;
		end else if (scl_hit) begin
			level_reg <= LEVEL_RST;
			limit_reg <= LIMIT_RST;
			supply_reg <= SUPPLY_RST;
		end else begin
			level_reg <= wr_level ? hwdata[23:0] : level_reg;
			limit_reg <= wr_limit ? hwdata[15:0] : limit_reg;
			supply_reg <= wr_supply ? hwdata[15:0] : supply_reg;
		end
	end

	// Low supply fault: set wins over read clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_flag_reg <= 1'b0;
		end else if (low_ev) begin
			low_flag_reg <= 1'b1;
		end else if (fault_rd) begin
			low_flag_reg <= 1'b0;
		end
	end

	// Interrupt status (write one to clear), mask and output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_reg <= '0;
			imask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			istat_reg <= ev | (istat_reg & ~(wr_istat ? hwdata[IRQ_W-1:0] : '0));
			imask_reg <= wr_imask ? hwdata[IRQ_W-1:0] : imask_reg;
			irq_reg <= |(istat_reg & imask_reg);
		end
	end

	// SCL low watchdog and shutdown hold until SCL rises
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_cnt_reg <= 32'h00000000;
			shut_reg <= 1'b0;
		end else begin
			scl_cnt_reg <= (active_mode && !pins.scl && !scl_hit) ? scl_cnt_reg + 32'h00000001
				: 32'h00000000;
			shut_reg <= scl_hit ? 1'b1 : (pins.scl ? 1'b0 : shut_reg);
		end
	end

	// Flash state sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			FL_IDLE: begin
				if (start_req) begin
					state_next = FL_CHECK;
				end
			end
			FL_CHECK: begin
				state_next = abort_now ? FL_IDLE : FL_RUN;
			end
			FL_RUN: begin
				if (run_end) begin
					state_next = FL_IDLE;
				end
			end
			default: begin
				state_next = FL_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= FL_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Step and duration timers, run only during the pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt_reg <= 16'h0000;
			dur_cnt_reg <= 16'h0000;
		end else if (!in_run) begin
			step_cnt_reg <= 16'h0000;
			dur_cnt_reg <= 16'h0000;
		end else begin
			step_cnt_reg <= step_tick ? 16'h0000 : step_cnt_reg + 16'h0001;
			dur_cnt_reg <= step_tick ? dur_cnt_reg + 16'h0001 : dur_cnt_reg;
		end
	end

	// Pulse levels: ramp, reductions and minimum tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reduced_reg <= 1'b0;
			lowered_reg <= 1'b0;
			cur1_reg <= 8'h00;
			cur2_reg <= 8'h00;
			min1_reg <= 8'h00;
			min2_reg <= 8'h00;
		end else if (in_check) begin
			reduced_reg <= pre_low;
			lowered_reg <= 1'b0;
			cur1_reg <= 8'h00;
			cur2_reg <= 8'h00;
			min1_reg <= pre_low ? reduced_lvl : lvl1;
			min2_reg <= pre_low ? reduced_lvl : lvl2;
		end else if (in_run) begin
			lowered_reg <= lowered_reg || run_low_ev;
			cur1_reg <= nxt1;
			cur2_reg <= nxt2;
			min1_reg <= (lowered_reg || txmask) && (cur1_reg < min1_reg) ? cur1_reg : min1_reg;
			min2_reg <= (lowered_reg || txmask) && (cur2_reg < min2_reg) ? cur2_reg : min2_reg;
		end
	end

	// Registered sink drives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drv1_reg <= 8'h00;
			drv2_reg <= 8'h00;
		end else begin
			drv1_reg <= d1;
			drv2_reg <= d2;
		end
	end

	assign hreadyout = ready_reg;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign first_sink_drive = drv1_reg;
	assign second_sink_drive = drv2_reg;
	assign shutdown = shut_reg;
	assign irq = irq_reg;
endmodule

/* rtl/flm_pin_if.sv */
`timescale 1ns/1ps
// Synchronised pin levels and trigger edge
interface flm_pin_if;
	logic torch;
	logic trig;
	logic trig_rise;
	logic scl;
	modport src(output torch, output trig, output trig_rise, output scl);
	modport dst(input torch, input trig, input trig_rise, input scl);
endinterface

/* rtl/flm_pin_sync.sv */
`timescale 1ns/1ps
module flm_pin_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic torch_raw,
	input wire logic trig_raw,
	input wire logic scl_raw,
	flm_pin_if.src pins
);
	logic trig_old_reg;
	wire [2:0] raw_vec = {scl_raw, trig_raw, torch_raw};
	wire [2:0] sync_vec;
	genvar i;
	// Two-stage synchroniser per pin, each stage pair owned by one process
	generate
		for (i = 0; i < 3; i++) begin : g_sync
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= raw_vec[i];
					sync_reg <= meta_reg;
				end
			end
			assign sync_vec[i] = sync_reg;
		end
	endgenerate
	// Edge history of the synchronised trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_old_reg <= 1'b0;
		end else begin
			trig_old_reg <= sync_vec[1];
		end
	end
	assign pins.torch = sync_vec[0];
	assign pins.trig = sync_vec[1];
	assign pins.scl = sync_vec[2];
	assign pins.trig_rise = sync_vec[1] & ~trig_old_reg;
endmodule

/* rtl/flm_pkg.sv */
package flm_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 250;
	localparam int STEP_US = 8;
	localparam int STEP_CYC = CLK_MHZ * STEP_US;
	localparam int TIMEOUT_MS = 100;
	localparam int TIMEOUT_CYC = CLK_MHZ * 1000 * TIMEOUT_MS;
	localparam int PWM_HZ_X100 = 3125000;
	// Scaled so that no intermediate product leaves the 32-bit range
	localparam int PWM_CYC = CLK_MHZ * 100000 / (PWM_HZ_X100 / 1000);
	localparam int PWM_STEPS = 16;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_LEVEL = 8'h04;
	localparam logic [7:0] A_LIMIT = 8'h08;
	localparam logic [7:0] A_SUPPLY = 8'h0c;
	localparam logic [7:0] A_FAULT = 8'h10;
	localparam logic [7:0] A_ISTAT = 8'h14;
	localparam logic [7:0] A_IMASK = 8'h18;
	localparam logic [7:0] A_READ = 8'h1c;
	localparam logic [7:0] A_STATE = 8'h20;
	// Control field positions
	localparam int C_MODE = 0;
	localparam int C_OUT_ON = 2;
	localparam int C_TORCH = 3;
	localparam int C_STROBE_ON = 5;
	localparam int C_STROBE_TYPE = 6;
	localparam int C_ABORT = 7;
	localparam int C_DUTY = 8;
	localparam int CTRL_W = 10;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
	localparam logic [23:0] LEVEL_RST = 24'h000000;
	localparam logic [15:0] LIMIT_RST = 16'h0040;
	localparam logic [15:0] SUPPLY_RST = 16'h0000;
	// Mode and torch pin codes
	localparam logic [1:0] MODE_EXT = 2'h0;
	localparam logic [1:0] MODE_IND = 2'h1;
	localparam logic [1:0] MODE_ASSIST = 2'h2;
	localparam logic [1:0] MODE_FLASH = 2'h3;
	localparam logic [1:0] TORCH_MASK = 2'h1;
	localparam logic [1:0] TORCH_EXT = 2'h2;
	localparam logic [7:0] MASK7 = 8'h7f;
	localparam logic [7:0] MASK6 = 8'h3f;
	// Interrupt status bits
	localparam int I_LOWSUP = 0;
	localparam int I_START = 1;
	localparam int I_END = 2;
	localparam int I_SDOWN = 3;
	localparam int IRQ_W = 4;
	typedef enum logic [2:0] {
		FL_IDLE = 3'b001,
		FL_CHECK = 3'b010,
		FL_RUN = 3'b100
	} flm_state_e;
endpackage

/* rtl/flm_pwm.sv */
`timescale 1ns/1ps
module flm_pwm #(
	parameter int PERIOD = flm_pkg::PWM_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] duty,
	output logic gate
);
	import flm_pkg::*;
	localparam int SLICE = PERIOD / PWM_STEPS;
	logic [15:0] cnt_reg;
	logic [15:0] limit;
	// On time is duty+1 sixteenths of the period
	assign limit = 16'(({14'h0000, duty} + 16'h0001) * SLICE);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 16'h0000;
			gate <= 1'b0;
		end else begin
			cnt_reg <= (cnt_reg == 16'(PERIOD - 1)) ? 16'h0000 : cnt_reg + 16'h0001;
			gate <= cnt_reg < limit;
		end
	end
endmodule

/* testbench/flm_checker.sv */
`timescale 1ns/1ps
module flm_checker #(
	parameter int SCL_TIMEOUT = 200
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic scl_pin,
	input wire logic [7:0] first_sink_drive,
	input wire logic [7:0] second_sink_drive,
	input wire logic shutdown
);
	import flm_pkg::*;
	logic rd_dp_reg;
	logic wc_dp_reg;
	logic [CTRL_W-1:0] ctl_reg;
	int scl_cnt_reg;
	wire take = hsel && htrans[1] && hready;
	wire [1:0] md = ctl_reg[1:0];
	wire on = ctl_reg[C_OUT_ON];
	wire [7:0] s1 = first_sink_drive;
	wire [7:0] s2 = second_sink_drive;
	wire zero_out = s1 == 8'h00 && s2 == 8'h00;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Data phase flags, control word shadow and SCL low counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_dp_reg <= 1'b0;
			wc_dp_reg <= 1'b0;
			ctl_reg <= CTRL_RST;
			scl_cnt_reg <= 0;
		end else begin
			rd_dp_reg <= take && !hwrite;
			wc_dp_reg <= take && hwrite && haddr[7:0] == A_CTRL;
			ctl_reg <= shutdown ? CTRL_RST : (wc_dp_reg ? hwdata[CTRL_W-1:0] : ctl_reg);
			scl_cnt_reg <= scl_pin ? 0 : scl_cnt_reg + int'(scl_cnt_reg < SCL_TIMEOUT + 8);
		end
	end
	sequence s_stby;
		(md != MODE_EXT && !on && ctl_reg[4:3] != TORCH_EXT && !shutdown)[*3];
	endsequence
	sequence s_ind;
		(md == MODE_IND && on && !shutdown)[*3];
	endsequence
	sequence s_low7;
		((md == MODE_ASSIST && on || md == MODE_EXT && ctl_reg[4:3] == TORCH_EXT) && !shutdown)[*3];
	endsequence
	sequence s_sclhi;
		scl_pin[*4];
	endsequence
	property p_bus;
		$past(hresetn) |-> hreadyout && !hresp;
	endproperty
	property p_rd_idle;
		!rd_dp_reg |-> hrdata == 32'h0;
	endproperty
	property p_standby;
		s_stby |-> zero_out;
	endproperty
	property p_ind;
		s_ind |-> s1[7:6] == 2'h0 && s2[7:6] == 2'h0;
	endproperty
	property p_low7;
		s_low7 |-> !s1[7] && !s2[7];
	endproperty
	property p_ramp;
		md == MODE_FLASH && $past(md, 2) == MODE_FLASH && s1 > $past(s1) |-> s1 == $past(s1) + 8'h01;
	endproperty
	property p_sd_cause;
		$rose(shutdown) |-> scl_cnt_reg >= SCL_TIMEOUT;
	endproperty
	property p_sd_rel;
		s_sclhi |-> !shutdown;
	endproperty
	property p_sd_zero;
		shutdown && $past(shutdown, 2) |-> zero_out;
	endproperty
	a_bus: assert property (p_bus) else $error("bus not ready or not okay");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
	a_standby: assert property (p_standby) else $error("drive in standby");
	a_ind: assert property (p_ind) else $error("indicator above six bits");
	a_low7: assert property (p_low7) else $error("top level bit used");
	a_ramp: assert property (p_ramp) else $error("flash ramp jump");
	a_sd_cause: assert property (p_sd_cause) else $error("early shutdown");
	a_sd_rel: assert property (p_sd_rel) else $error("shutdown with SCL high");
	a_sd_zero: assert property (p_sd_zero) else $error("drive in shutdown");
endmodule

bind flm_flash_ctrl flm_checker #(.SCL_TIMEOUT(SCL_TIMEOUT)) u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
	.hrdata, .hresp, .scl_pin, .first_sink_drive, .second_sink_drive, .shutdown
);

/* testbench/flm_host.sv */
`timescale 1ns/1ps
module flm_host (
	input wire logic burst,
	input wire logic hold_low,
	output logic scl_pin
);
	// Pulled-up SCL: 32 ns clock in bursts, held low when the host loses power
	initial begin
		scl_pin = 1'b1;
		forever #16 scl_pin = hold_low ? 1'b0 : (burst ? !scl_pin : 1'b1);
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	import flm_pkg::*;
	localparam int TO = 200;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic torch_pin = 1'b0;
	logic trigger_pin = 1'b0;
	logic [7:0] supply_level = 8'h80;
	logic burst = 1'b0;
	logic hold_low = 1'b0;
	logic hreadyout, hresp, scl_pin, shutdown, irq;
	logic [31:0] hrdata, rd;
	logic [7:0] s1, s2, mx;
	logic [9:0] cv [4] = '{10'h006, 10'h305, 10'h001, 10'h010};
	logic [7:0] ev [4] = '{8'h7f, 8'h3f, 8'h00, 8'h7f};
	int ec [4] = '{128, 32, 0, 128};
	int fail_count = 0;
	int tests_run = 0;
	int on_cnt;
	// Bus clock
	always #2 hclk = !hclk;
	flm_flash_ctrl #(.PWM_PERIOD(64), .SCL_TIMEOUT(TO)) dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .torch_pin, .trigger_pin,
		.scl_pin, .supply_level, .first_sink_drive(s1), .second_sink_drive(s2),
		.shutdown, .irq
	);
	flm_host host (.burst, .hold_low, .scl_pin);
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic edge_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: bus stuck", $time);
			print_verdict();
		end
	endtask
	// One single AHB transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		rd = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wait_s1(input logic [7:0] e, input int lim);
		int n;
		n = 0;
		while (s1 !== e && n < lim) begin
			@(posedge hclk);
			n++;
		end
		chk(32'(s1), 32'(e));
		// A wait that ran out ends the run
		if (s1 !== e) begin
			print_verdict();
		end
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rc(A_LIMIT, 32'h40);
		rc(8'h30, 32'h0);
		rc(A_STATE, 32'h1);
		xfer(1'b1, A_LEVEL, 32'h00ffff);
		for (int i = 0; i < 4; i++) begin
			torch_pin <= (i == 3);
			xfer(1'b1, A_CTRL, 32'(cv[i]));
			repeat (8) @(posedge hclk);
			mx = 8'h0;
			on_cnt = 0;
			repeat (128) begin
				@(posedge hclk);
				mx = (s1 > mx) ? s1 : mx;
				on_cnt += int'(s1 != 8'h0);
			end
			chk(32'(mx), 32'(ev[i]));
			chk(32'(on_cnt), 32'(ec[i]));
		end
		torch_pin <= 1'b0;
		xfer(1'b1, A_LEVEL, 32'h010203);
		xfer(1'b1, A_LIMIT, 32'h5);
		xfer(1'b1, A_SUPPLY, 32'h0);
		xfer(1'b1, A_IMASK, 32'h6);
		xfer(1'b1, A_CTRL, 32'h7);
		wait_s1(8'h3, 8000);
		chk(32'(s2), 32'h2);
		rc(A_READ, 32'h02030203);
		wait_s1(8'h0, 12000);
		repeat (4) @(posedge hclk);
		chk(32'(irq), 32'h1);
		rc(A_ISTAT, 32'h6);
		rc(A_READ, 32'h02030203);
		xfer(1'b1, A_ISTAT, 32'h6);
		xfer(1'b1, A_IMASK, 32'h8);
		chk(32'(irq), 32'h0);
		xfer(1'b1, A_SUPPLY, 32'h5000);
		xfer(1'b1, A_CTRL, 32'h7);
		wait_s1(8'h2, 6000);
		supply_level <= 8'h40;
		wait_s1(8'h1, 2100);
		supply_level <= 8'h80;
		wait_s1(8'h0, 12000);
		xfer(1'b0, A_READ, 32'h0);
		chk(32'(rd[23:16]), 32'h1);
		chk(32'(irq), 32'h0);
		rc(A_FAULT, 32'h1);
		rc(A_FAULT, 32'h0);
		xfer(1'b1, A_SUPPLY, 32'h50);
		supply_level <= 8'h40;
		xfer(1'b1, A_CTRL, 32'h87);
		repeat (2500) @(posedge hclk);
		chk(32'(s1), 32'h0);
		rc(A_CTRL, 32'h83);
		rc(A_FAULT, 32'h1);
		xfer(1'b1, A_CTRL, 32'h7);
		wait_s1(8'h1, 4000);
		repeat (2500) @(posedge hclk);
		chk(32'(s1), 32'h1);
		wait_s1(8'h0, 12000);
		supply_level <= 8'h80;
		xfer(1'b1, A_SUPPLY, 32'h0);
		xfer(1'b1, A_CTRL, 32'hf);
		wait_s1(8'h3, 8000);
		torch_pin <= 1'b1;
		wait_s1(8'h1, 8);
		wait_s1(8'h0, 12000);
		torch_pin <= 1'b0;
		xfer(1'b1, A_CTRL, 32'h27);
		trigger_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		trigger_pin <= 1'b0;
		wait_s1(8'h1, 3000);
		wait_s1(8'h0, 12000);
		xfer(1'b1, A_CTRL, 32'h67);
		trigger_pin <= 1'b1;
		wait_s1(8'h1, 3000);
		trigger_pin <= 1'b0;
		wait_s1(8'h0, 8);
		xfer(1'b1, A_CTRL, 32'h6);
		xfer(1'b1, A_ISTAT, 32'hf);
		burst <= 1'b1;
		repeat (400) @(posedge hclk);
		chk(32'(shutdown), 32'h0);
		burst <= 1'b0;
		hold_low <= 1'b1;
		repeat (TO + 10) @(posedge hclk);
		chk(32'(shutdown), 32'h1);
		chk(32'(irq), 32'h1);
		rc(A_CTRL, 32'h0);
		hold_low <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(32'(shutdown), 32'h0);
		print_verdict();
	end
endmodule
